// [itw_interval_watchdog.sv]
// Basic interval timer with prescaler and 7-bit watchdog behind Avalon-MM.
//
// Functional notes
// - Free-running 8-bit interval counter, halted only in STOP without RC.
// - Count per prescale pulse; wrap sets flag.
// - Control bits 2:0 pick divide 8..1024.
// - Clear bit zeroes counter, self-clears next cycle.
// - Shared address: read counter, write control.
// - RC-mode STOP keeps only timer, watchdog.
// - Watchdog request when count equals compare[6:0].
// - Reset-select: reset pin low, else interrupt.
// - Reset-select at control bit 4, reset zero.
// - Compare bit 7 clears watchdog, self-clears.
// - Watchdog steps once per interval period.
// - Watchdog starts after interval timer clear.
// - STOP without RC holds watchdog count.
// - RC mode steps every 2^8 RC periods.
// - Watchdog reset in sub clock restarts main.
// - Watchdog interrupt sets watchdog flag.
`timescale 1ns/100ps
`default_nettype none
`include "itw_regs.svh"

// The block answers every bus access after exactly one wait state.
// Reads return registered data, and writes land on the answering edge.
// The shared address returns the live interval count on a read.
// A write to that address loads the clock control byte instead.
// The control clear bit and the compare clear bit are one-cycle strobes.
// Software never has to write them back to zero.
// The watchdog stays idle until the interval timer has been cleared once.
// Its first period starts with a zeroed interval count, so it is short by less than one prescaler tick.
// In STOP without RC operation, the interval counter and the watchdog freeze; the prescaler keeps running.
// In RC watchdog mode, the watchdog steps from the RC divider instead.
// A watchdog reset drives the reset pin for a fixed number of clocks.
// It also drops the STOP and sub clock requests.
// That turns the main oscillator back on at once.
// Status bits are sticky, and a new event beats a clear in the same cycle.

module itw_interval_watchdog (
    input  wire logic                     clk,           // System clock.
    input  wire logic                     rstn,          // Async reset, low.
    input  wire logic                     rcTick,        // RC oscillator tick.
    input  wire logic [`ITW_ADDR_W-1:0]   address,       // Byte address.
    input  wire logic                     read,          // Read request.
    input  wire logic                     write,         // Write request.
    input  wire logic [31:0]              writedata,     // Write data.
    input  wire logic [3:0]               byteenable,    // Byte lanes.
    output logic      [31:0]              readdata,      // Read data.
    output logic                          waitrequest,   // Stall.
    output logic                          irq,           // Level interrupt.
    output logic                          resetPinLow,   // Drive reset pin.
    output logic                          mainOscOn,     // Main osc enable.
    output logic                          haltOthers     // Halt other blocks.
);

    logic [7:0]  intervalCount;
    logic [7:0]  ctrl;
    logic [7:0]  wdtCompare;
    logic [6:0]  wdtCount;
    logic [1:0]  irqStatus;
    logic [1:0]  irqMask;
    logic [1:0]  modeCtrl;
    logic [`ITW_PRESCALE_W-1:0] prescaler;
    logic [`ITW_RC_STEP_W-1:0]  rcDiv;
    logic        wdtArmed;
    logic        ackPending;
    logic        wdtHit;
    logic        prescaleTick;
    logic        intervalWrap;
    logic        wdtStep;
    logic        rstPulseDone;
    logic [7:0]  rstCount;
    itw_pkg::itw_mode_type mode;

    // Write strobe helper for one register address.
    function automatic logic wr_hit(input logic [`ITW_ADDR_W-1:0] a);
        wr_hit = write && !waitrequest && (address == a) && byteenable[0];
    endfunction

    // One wait state per access: waitrequest drops in the second cycle.
    // The pending flag falls again on the answering edge.
    // A master that keeps its request up therefore starts a fresh access.
    // That is why back-to-back requests still see one wait state each.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ackPending <= 1'b0;
        end else begin
            ackPending <= (read || write) && !ackPending;
        end
    end
    assign waitrequest = (read || write) && !ackPending;

    // Mode decode from the STOP request and the RC select bit.
    // The RC select bit only matters once STOP has been requested.
    // Outside STOP the mode is always RUN, so the watchdog steps from the interval timer.
    always_comb begin
        if (!modeCtrl[`ITW_MODE_STOP_BIT]) begin
            mode = itw_pkg::ITW_RUN;
        end else if (ctrl[`ITW_CTL_RC_SELECT_BIT]) begin
            mode = itw_pkg::ITW_STOP_RC;
        end else begin
            mode = itw_pkg::ITW_STOP_HOLD;
        end
    end
    assign haltOthers = (mode != itw_pkg::ITW_RUN);

    // Free-running prescaler; the tick is the selected bit's carry.
    // The prescaler is never cleared by software.
    // After a new code the first tick may come early or late.
    // Later ticks come at the selected ratio.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescaler <= '0;
        end else begin
            prescaler <= prescaler + 1'b1;
        end
    end
    // Tick when all bits below the selected tap are ones.
    always_comb begin
        logic [3:0] sh;
        logic [`ITW_PRESCALE_W-1:0] m;
        sh = 4'(ctrl[`ITW_CTL_PRESCALE_MSB:`ITW_CTL_PRESCALE_LSB])
             + 4'(`ITW_PRESCALE_BASE_SH);
        m = `ITW_PRESCALE_W'((11'h001 << sh) - 11'h001);
        prescaleTick = ((prescaler & m) == m)
                       && (mode != itw_pkg::ITW_STOP_HOLD);
    end

    // Interval counter: counts, wraps, cleared by the clear bit.
    // A clear in the same cycle as a tick wins, so the count restarts at zero.
    // The wrap flag is still raised if that tick was the wrap.
    assign intervalWrap = prescaleTick && (intervalCount == 8'hff);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intervalCount <= 8'h00;
        end else if (ctrl[`ITW_CTL_CLEAR_BIT]) begin
            intervalCount <= 8'h00;
        end else if (prescaleTick) begin
            intervalCount <= intervalCount + 8'h01;
        end
    end

    // Control register write at the shared address; clear bit self-clears.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `ITW_CTL_RESET;
        end else if (wr_hit(`ITW_OFS_COUNT_CTRL)) begin
            ctrl <= writedata[7:0];
        end else begin
            ctrl[`ITW_CTL_CLEAR_BIT] <= 1'b0;
        end
    end

    // Watchdog compare register; bit 7 self-clears after one cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdtCompare <= `ITW_WDT_RESET;
        end else if (wr_hit(`ITW_OFS_WDT_COMPARE)) begin
            wdtCompare <= writedata[7:0];
        end else begin
            wdtCompare[`ITW_WDT_CLEAR_BIT] <= 1'b0;
        end
    end

    // Mode control: STOP request and sub clock select.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeCtrl <= 2'h0;
        end else if (wr_hit(`ITW_OFS_MODE_CTRL)) begin
            modeCtrl <= writedata[1:0];
        end else if (wdtHit && ctrl[`ITW_CTL_WDT_RESET_BIT]) begin
            modeCtrl <= 2'h0;
        end
    end
    assign mainOscOn = !modeCtrl[`ITW_MODE_SUBCLK_BIT]
                       || resetPinLow;

    // RC divider, 2^8 RC ticks per watchdog step in RC mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rcDiv <= '0;
        end else if (rcTick) begin
            rcDiv <= rcDiv + 1'b1;
        end
    end

    // Watchdog starts only after the interval timer has been cleared.
    // Once armed, it stays armed until the next system reset.
    // Disabling the reset select does not disarm it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdtArmed <= 1'b0;
        end else if (ctrl[`ITW_CTL_CLEAR_BIT]) begin
            wdtArmed <= 1'b1;
        end
    end

    // Step source: interval wrap normally, RC divider in RC STOP mode.
    always_comb begin
        case (mode)
            itw_pkg::ITW_STOP_RC:
                wdtStep = rcTick && (rcDiv == '1);
            itw_pkg::ITW_STOP_HOLD:
                wdtStep = 1'b0;
            default:
                wdtStep = intervalWrap;
        endcase
    end

    // Watchdog counter and compare.
    // A hit restarts the count at zero.
    // So the period is the compare value plus one step.
    // A software clear wins over a step in the same cycle.
    // Clearing in time is what keeps the watchdog from firing.
    assign wdtHit = wdtArmed && (wdtCount == wdtCompare[6:0]) && wdtStep;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdtCount <= 7'h00;
        end else if (wdtCompare[`ITW_WDT_CLEAR_BIT] || wdtHit) begin
            wdtCount <= 7'h00;
        end else if (wdtArmed && wdtStep) begin
            wdtCount <= wdtCount + 7'h01;
        end
    end

    // Reset pulse on the reset pin after a watchdog reset.
    // The pulse length is counted in clocks from a fixed time.
    // A second hit during the pulse restarts the full length.
    // Otherwise the pulse could end before the chip has settled.
    assign rstPulseDone = (rstCount == 8'h00);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstCount <= 8'h00;
        end else if (wdtHit && ctrl[`ITW_CTL_WDT_RESET_BIT]) begin
            rstCount <= 8'(`ITW_RESET_PULSE_CYC);
        end else if (!rstPulseDone) begin
            rstCount <= rstCount - 8'h01;
        end
    end
    assign resetPinLow = !rstPulseDone;

    // Sticky status; set wins over write-one-to-clear.
    // A watchdog hit with reset select set raises no status bit.
    // It drives the reset pin instead.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus <= 2'h0;
        end else begin
            logic [1:0] next_status;
            next_status = irqStatus;
            if (wr_hit(`ITW_OFS_IRQ_STATUS)) begin
                next_status = next_status & ~writedata[1:0];
            end
            if (intervalWrap) begin
                next_status[`ITW_IRQ_INTERVAL_BIT] = 1'b1;
            end
            if (wdtHit && !ctrl[`ITW_CTL_WDT_RESET_BIT]) begin
                next_status[`ITW_IRQ_WATCHDOG_BIT] = 1'b1;
            end
            irqStatus <= next_status;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqMask <= 2'h0;
        end else if (wr_hit(`ITW_OFS_IRQ_MASK)) begin
            irqMask <= writedata[1:0];
        end
    end
    assign irq = |(irqStatus & irqMask);

    // Read data registered ahead of the answering cycle.
    // The value is taken in the first cycle of the access.
    // It then stands at the edge where waitrequest is low.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0;
        end else if (read && !ackPending) begin
            if (address == `ITW_OFS_COUNT_CTRL) begin
                readdata <= {24'h0, intervalCount};
            end else if (address == `ITW_OFS_WDT_COMPARE) begin
                readdata <= {24'h0, wdtCompare};
            end else if (address == `ITW_OFS_IRQ_STATUS) begin
                readdata <= {30'h0, irqStatus};
            end else if (address == `ITW_OFS_IRQ_MASK) begin
                readdata <= {30'h0, irqMask};
            end else if (address == `ITW_OFS_MODE_CTRL) begin
                readdata <= {30'h0, modeCtrl};
            end else begin
                readdata <= 32'h0;
            end
        end
    end

    // Assertions guarding the main behaviours.
    a_clear_self: assert property (@(posedge clk) disable iff (!rstn)
        ctrl[`ITW_CTL_CLEAR_BIT] && !wr_hit(`ITW_OFS_COUNT_CTRL)
        |=> !ctrl[`ITW_CTL_CLEAR_BIT] && intervalCount == 8'h00)
        else $error("interval clear bit did not clear");
    a_wrap_flag: assert property (@(posedge clk) disable iff (!rstn)
        intervalWrap |=> irqStatus[`ITW_IRQ_INTERVAL_BIT]
        && intervalCount == 8'h00)
        else $error("wrap did not set flag");
    a_wdt_clear: assert property (@(posedge clk) disable iff (!rstn)
        $rose(wdtCompare[7]) |=> wdtCount == 7'h00 && !wdtCompare[7])
        else $error("watchdog clear failed");
    a_wdt_hold: assert property (@(posedge clk) disable iff (!rstn)
        mode == itw_pkg::ITW_STOP_HOLD && !wdtCompare[7]
        |=> $stable(wdtCount))
        else $error("watchdog moved in stop");
    a_reset_pin: assert property (@(posedge clk) disable iff (!rstn)
        wdtHit && ctrl[4] |=> resetPinLow && mainOscOn)
        else $error("watchdog reset not driven");
    a_wdt_irq: assert property (@(posedge clk) disable iff (!rstn)
        wdtHit && !ctrl[4] |=> irqStatus[`ITW_IRQ_WATCHDOG_BIT]
        && !resetPinLow)
        else $error("watchdog interrupt not flagged");
    a_wdt_armed: assert property (@(posedge clk) disable iff (!rstn)
        !wdtArmed |=> wdtCount == 7'h00)
        else $error("watchdog counted before arm");
    a_shared_read: assert property (@(posedge clk) disable iff (!rstn)
        read && !ackPending && address == `ITW_OFS_COUNT_CTRL
        |=> readdata[7:0] == $past(intervalCount))
        else $error("shared address read wrong");
    a_halt_out: assert property (@(posedge clk) disable iff (!rstn)
        modeCtrl[0] |-> haltOthers)
        else $error("stop did not halt");


    // The bus answers exactly one cycle after a wait state.
    a_bus_one_wait: assert property (
        @(posedge clk) disable iff (!rstn)
        waitrequest |=> !waitrequest)
        else $error("bus answer did not follow the wait state");

    // Without a clear, the interval count moves only by its tick.
    a_count_step: assert property (
        @(posedge clk) disable iff (!rstn)
        !ctrl[`ITW_CTL_CLEAR_BIT]
        |=> intervalCount
            == $past(intervalCount) + 8'($past(prescaleTick)))
        else $error("interval counter skipped or stalled");

    // A write at the shared address loads the control byte.
    a_ctrl_write: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_hit(`ITW_OFS_COUNT_CTRL)
        |=> ctrl == $past(writedata[7:0]))
        else $error("control write did not land");

    // Status bits hold until software clears them.
    a_status_sticky: assert property (
        @(posedge clk) disable iff (!rstn)
        irqStatus != 2'h0 && !wr_hit(`ITW_OFS_IRQ_STATUS)
        |=> (irqStatus & $past(irqStatus)) == $past(irqStatus))
        else $error("status bit dropped without a clear");

    // An armed watchdog advances by one on each step that is not a hit or a clear.
    a_wdt_step: assert property (
        @(posedge clk) disable iff (!rstn)
        wdtArmed && wdtStep && !wdtHit && !wdtCompare[`ITW_WDT_CLEAR_BIT]
        |=> wdtCount == $past(wdtCount) + 7'h01)
        else $error("watchdog did not step");

    // A reset pulse starts with its full length loaded.
    a_pulse_len: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(resetPinLow) |-> rstCount == 8'(`ITW_RESET_PULSE_CYC))
        else $error("reset pulse length wrong");

    c_wrap: cover property (@(posedge clk) intervalWrap);
    c_wdt_irq: cover property (@(posedge clk) wdtHit && !ctrl[4]);
    c_wdt_rst: cover property (@(posedge clk) wdtHit && ctrl[4]);
    c_rc_mode: cover property (@(posedge clk) mode == itw_pkg::ITW_STOP_RC && wdtStep);
    c_wdt_clear: cover property (@(posedge clk) wdtCompare[7]);

endmodule

`default_nettype wire

// [itw_regs.svh]
// Register offsets, field positions, reset values and timing counts for the interval timer and watchdog.
`ifndef ITW_REGS_SVH
`define ITW_REGS_SVH

// Byte addresses on the register bus (word aligned except the shared count address).
`define ITW_ADDR_W            8
`define ITW_OFS_COUNT_CTRL    8'hf2
`define ITW_OFS_WDT_COMPARE   8'hf4
`define ITW_OFS_IRQ_STATUS    8'hf8
`define ITW_OFS_IRQ_MASK      8'hfc
`define ITW_OFS_MODE_CTRL     8'hf0

// Fields of the timer clock control register.
`define ITW_CTL_PRESCALE_LSB  0
`define ITW_CTL_PRESCALE_MSB  2
`define ITW_CTL_CLEAR_BIT     3
`define ITW_CTL_WDT_RESET_BIT 4
`define ITW_CTL_RC_SELECT_BIT 5
`define ITW_CTL_RESET         8'h00

// Fields of the watchdog compare register.
`define ITW_WDT_CLEAR_BIT     7
`define ITW_WDT_RESET         8'h00

// Interrupt status and mask bits.
`define ITW_IRQ_INTERVAL_BIT  0
`define ITW_IRQ_WATCHDOG_BIT  1

// Mode control register bits.
`define ITW_MODE_STOP_BIT     0
`define ITW_MODE_SUBCLK_BIT   1

// Base prescaler ratio is divide-by-8; the code adds to the shift.
`define ITW_PRESCALE_BASE_SH  3
`define ITW_PRESCALE_W        10

// RC mode watchdog step is 2^8 RC periods.
`define ITW_RC_STEP_W         8

// Width of the reset pulse driven on a watchdog reset, in clocks.
`define ITW_RESET_PULSE_NS    1000
`define ITW_CLK_NS            20
`define ITW_RESET_PULSE_CYC   ((`ITW_RESET_PULSE_NS + `ITW_CLK_NS - 1) / `ITW_CLK_NS)

`endif

// [itw_pkg.sv]
// Types shared by the interval timer and watchdog.
package itw_pkg;
    typedef enum logic [1:0] {
        ITW_RUN,
        ITW_STOP_HOLD,
        ITW_STOP_RC
    } itw_mode_type;
endpackage

// [itw_testbench.sv]
// Self-checking bench for the interval timer and watchdog block.
`timescale 1ns/100ps
`default_nettype none
`include "itw_regs.svh"

module testbench;
    logic        clk;            // System clock.
    logic        rstn;           // Reset, active low.
    logic        rcTick;         // RC oscillator tick.
    logic [7:0]  address;        // Bus address.
    logic        read;           // Bus read.
    logic        write;          // Bus write.
    logic [31:0] writedata;      // Bus write data.
    logic [3:0]  byteenable;     // Bus byte lanes.
    logic [31:0] readdata;       // Bus read data.
    logic        waitrequest;    // Bus stall.
    logic        irq;            // Interrupt output.
    logic        resetPinLow;    // Reset pin drive.
    logic        mainOscOn;      // Main oscillator enable.
    logic        haltOthers;     // Halt of other blocks.
    logic [2:0]  rcPhase;        // Divider for the RC tick.
    logic [31:0] rdValue;        // Last value read.
    int          nMismatch;      // Mismatches seen.
    int          samplesChecked; // Comparisons made.

    itw_interval_watchdog itw_interval_watchdog_inst (
        .clk         (clk),
        .rstn        (rstn),
        .rcTick      (rcTick),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .irq         (irq),
        .resetPinLow (resetPinLow),
        .mainOscOn   (mainOscOn),
        .haltOthers  (haltOthers)
    );

    // Clock of 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The RC tick pulses once every eight clocks.
    always @(posedge clk) begin
        rcPhase <= rcPhase + 3'h1;
        rcTick  <= (rcPhase == 3'h0);
    end

    // Prints the verdict and ends the run.
    task automatic closeOut();
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compares one value and reports a difference.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Checks that a value lies between two bounds.
    task automatic chkRange(input logic [31:0] got, input int lo, input int hi);
        samplesChecked++;
        if ($isunknown(got) || !(got >= lo && got <= hi)) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, lo);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is sampled low.
    task automatic busCycle(input logic isWrite, input logic [7:0] addr,
                            input logic [31:0] data);
        @(posedge clk);
        address   <= addr;
        writedata <= data;
        write     <= isWrite;
        read      <= !isWrite;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rdValue = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        // Let the answering edge's updates settle before outputs are checked.
        @(posedge clk);
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        busCycle(1'b1, addr, data);
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp);
        busCycle(1'b0, addr, 32'h0);
        chk(rdValue, exp);
    endtask

    // Gives up if the tests hang.
    initial begin
        repeat (60000) @(posedge clk);
        nMismatch++;
        closeOut();
    end

    // Main test sequence.
    initial begin
        int i;
        int c;
        int k;
        logic seenReset;
        rstn = 1'b0; rcPhase = 3'h0; rcTick = 1'b0; address = 8'h00;
        read = 1'b0; write = 1'b0; writedata = 32'h0; byteenable = 4'hf;
        nMismatch = 0; samplesChecked = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, resetPinLow}, 32'h0);
        chk({31'h0, mainOscOn}, 32'h1);
        chk({31'h0, haltOthers}, 32'h0);
        chk({31'h0, waitrequest}, 32'h0);
        rdChk(`ITW_OFS_WDT_COMPARE, 32'h0);
        rdChk(`ITW_OFS_IRQ_MASK, 32'h0);
        rdChk(`ITW_OFS_MODE_CTRL, 32'h0);
        // Unmapped places and disabled lanes take no write.
        wr(8'h10, 32'hff);
        rdChk(8'h10, 32'h0);
        byteenable <= 4'h0;
        wr(`ITW_OFS_IRQ_MASK, 32'h3);
        byteenable <= 4'hf;
        rdChk(`ITW_OFS_IRQ_MASK, 32'h0);
        // Each prescaler code gives about four counts in 4 x ratio clocks.
        for (c = 0; c < 8; c++) begin
            wr(`ITW_OFS_COUNT_CTRL, 32'h08 | c);
            repeat (4 * (8 << c)) @(posedge clk);
            busCycle(1'b0, `ITW_OFS_COUNT_CTRL, 32'h0);
            chkRange(rdValue, 3, 5);
        end
        // Wrap after 256 counts of 8 clocks sets the interval flag.
        wr(`ITW_OFS_COUNT_CTRL, 32'h08);
        wr(`ITW_OFS_IRQ_STATUS, 32'h3);
        repeat (1990) @(posedge clk);
        busCycle(1'b0, `ITW_OFS_IRQ_STATUS, 32'h0);
        chk(rdValue & 32'h1, 32'h0);
        repeat (100) @(posedge clk);
        busCycle(1'b0, `ITW_OFS_IRQ_STATUS, 32'h0);
        chk(rdValue & 32'h1, 32'h1);
        wr(`ITW_OFS_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`ITW_OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`ITW_OFS_IRQ_MASK, 32'h0);
        // STOP halts the rest of the chip.
        wr(`ITW_OFS_MODE_CTRL, 32'h1);
        chk({31'h0, haltOthers}, 32'h1);
        wr(`ITW_OFS_MODE_CTRL, 32'h0);
        chk({31'h0, haltOthers}, 32'h0);
        // Watchdog interrupt after (2 + 1) intervals of 2048 clocks.
        wr(`ITW_OFS_WDT_COMPARE, 32'h82);
        wr(`ITW_OFS_COUNT_CTRL, 32'h08);
        wr(`ITW_OFS_IRQ_STATUS, 32'h3);
        wr(`ITW_OFS_IRQ_MASK, 32'h2);
        repeat (4000) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        for (i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, resetPinLow}, 32'h0);
        rdChk(`ITW_OFS_WDT_COMPARE, 32'h02);
        wr(`ITW_OFS_IRQ_STATUS, 32'h2);
        wr(`ITW_OFS_IRQ_MASK, 32'h0);
        // Watchdog reset from the sub clock restarts the main oscillator.
        wr(`ITW_OFS_MODE_CTRL, 32'h2);
        chk({31'h0, mainOscOn}, 32'h0);
        wr(`ITW_OFS_WDT_COMPARE, 32'h81);
        wr(`ITW_OFS_COUNT_CTRL, 32'h18);
        for (i = 0; i < 8000 && resetPinLow !== 1'b1; i++) @(posedge clk);
        for (i = 0; i < 200 && resetPinLow === 1'b1; i++) @(posedge clk);
        chk(i, `ITW_RESET_PULSE_CYC);
        chk({31'h0, mainOscOn}, 32'h1);
        // Clearing in time keeps the watchdog reset away.
        seenReset = 1'b0;
        for (k = 0; k < 4; k++) begin
            wr(`ITW_OFS_WDT_COMPARE, 32'h81);
            for (i = 0; i < 1500; i++) begin
                @(posedge clk);
                seenReset = seenReset | resetPinLow;
            end
        end
        chk({31'h0, seenReset}, 32'h0);
        // RC watchdog mode in STOP steps from the RC divider.
        wr(`ITW_OFS_COUNT_CTRL, 32'h28);
        wr(`ITW_OFS_WDT_COMPARE, 32'h81);
        wr(`ITW_OFS_IRQ_STATUS, 32'h3);
        wr(`ITW_OFS_IRQ_MASK, 32'h2);
        wr(`ITW_OFS_MODE_CTRL, 32'h1);
        chk({31'h0, haltOthers}, 32'h1);
        for (i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        chkRange(i, 1500, 4200);
        wr(`ITW_OFS_MODE_CTRL, 32'h0);
        chk({31'h0, haltOthers}, 32'h0);
        closeOut();
    end
endmodule

`default_nettype wire
